// ==== ecf_pkg.sv ====
// ecf_pkg: constants and carrier types for the error class flag latch
// assumes: single 25 MHz clock domain, 16-bit register port
package ecf_pkg;

  // -------------------------------------------------------------------------
  // register port geometry
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DET_N  = 8;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS    = 8'h00; // system flag word
  localparam logic [7:0] OFS_DET_BASE = 8'h10; // detail words, one per 4 bytes
  localparam logic [7:0] OFS_DET_LAST = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  localparam logic [7:0] OFS_STATUS   = 8'h38;

  // -------------------------------------------------------------------------
  // flag word field positions
  // -------------------------------------------------------------------------
  localparam int unsigned BIT_SUM     = 10;
  localparam int unsigned BIT_FATAL   = 11;
  localparam int unsigned BIT_SERIOUS = 12;
  localparam int unsigned BIT_LIGHT   = 13;
  localparam int unsigned BIT_WARN    = 14;
  localparam int unsigned NCLASS      = 4;

  // status word field positions
  localparam int unsigned BIT_BUSERR  = 0;
  localparam int unsigned BIT_REMERR  = 1;

  // reset values
  localparam logic [3:0]  RST_CLASS = 4'h0;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned LONG_PRESS_MS = 10_000;
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ECF_FATAL   = 2'h0,
    ECF_SERIOUS = 2'h1,
    ECF_LIGHT   = 2'h2,
    ECF_WARN    = 2'h3
  } ecf_class_t;

  typedef struct packed {
    ecf_class_t              cls;    // severity class of the new error
    logic                    bus;    // error concerns the system bus
    logic [DET_N-1:0][15:0]  detail; // detail words of the new error
  } ecf_report_t;

endpackage

// ==== ecf_latch.sv ====
// ecf_latch: latched severity class flags, summary flag, detail words
// assumes: error reports and commands come from logic on clk_i;
// run/stop switch and test button are raw pins
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module ecf_latch #(
  parameter int unsigned LONG_PRESS = ecf_pkg::LONG_PRESS_CYC // test button hold, cycles
) (
  input  wire logic                  clk_i,          // 25 MHz system clock
  input  wire logic                  arst_n_i,       // async reset, power-on
  input  wire logic [7:0]            addr_i,         // register byte address
  input  wire logic [15:0]           wdata_i,        // write data
  input  wire logic                  we_i,           // write strobe
  input  wire logic                  re_i,           // read strobe
  output logic      [15:0]           rdata_o,        // read data, cycle after re_i
  input  wire logic                  err_valid_i,    // new error pulse
  input  wire ecf_pkg::ecf_report_t  err_i,          // new error report
  input  wire logic [3:0]            cause_i,        // causes still present, per class
  input  wire logic                  ram_fail_i,     // user program RAM test failed
  input  wire logic                  cold_start_i,   // cold start command pulse
  input  wire logic                  run_stop_i,     // run/stop switch pin, 1 = run
  input  wire logic                  bus_ack_i,      // bus error acknowledge pulse
  input  wire logic                  test_btn_i,     // remote test button pin
  output logic [3:0]                 class_led_o,    // class indicators
  output logic                       sum_led_o,      // summary indicator
  output logic                       bus_led_o,      // bus error indicator
  output logic                       remote_err_o,   // error stored in remote module
  output logic                       remote_clr_o,   // remote error cleared pulse
  output logic                       irq_o           // interrupt level
);

  localparam int unsigned CNT_W = $clog2(LONG_PRESS + 1);

  // elaboration check
  if (LONG_PRESS < 1) begin : g_bad_press
    $error("LONG_PRESS must be at least one cycle");
  end

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] run_sync_q;
  logic [1:0] btn_sync_q;
  logic       run_prev_q;

  // two flops per pin, then an edge store on the run/stop pin only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_sync_q <= 2'h0;
      btn_sync_q <= 2'h0;
      run_prev_q <= 1'b0;
    end else begin
      run_sync_q <= {run_sync_q[0], run_stop_i};
      btn_sync_q <= {btn_sync_q[0], test_btn_i};
      run_prev_q <= run_sync_q[1];
    end
  end

  wire run_rise = run_sync_q[1] & ~run_prev_q;
  wire btn_lvl  = btn_sync_q[1];

  // -------------------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------------------
  wire wr_flags = we_i & (addr_i == ecf_pkg::OFS_FLAGS);
  wire wr_stat  = we_i & (addr_i == ecf_pkg::OFS_IRQ_STAT);
  wire wr_mask  = we_i & (addr_i == ecf_pkg::OFS_IRQ_MASK);
  wire det_hit  = (addr_i >= ecf_pkg::OFS_DET_BASE) && (addr_i <= ecf_pkg::OFS_DET_LAST)
                  && (addr_i[1:0] == 2'h0);
  wire [7:0] det_ofs = addr_i - ecf_pkg::OFS_DET_BASE;
  wire [2:0] det_idx = det_ofs[4:2];

  // -------------------------------------------------------------------------
  // classification
  // -------------------------------------------------------------------------
  // RAM test fault is serious
  wire ecf_pkg::ecf_class_t new_cls = ram_fail_i ? ecf_pkg::ECF_SERIOUS : err_i.cls;
  wire new_err = err_valid_i | ram_fail_i;

  logic [3:0] new_onehot;
  assign new_onehot = new_err ? (4'h1 << new_cls) : 4'h0;

  wire [3:0] set_v = new_onehot | cause_i;

  // -------------------------------------------------------------------------
  // acknowledgement sources
  // -------------------------------------------------------------------------
  logic [3:0] cls_q;
  logic       sum_q;
  logic       bus_err_q;
  logic       remote_q;

  wire sw_clr_light = wr_flags & ~wdata_i[ecf_pkg::BIT_LIGHT];
  wire sw_clr_warn  = wr_flags & ~wdata_i[ecf_pkg::BIT_WARN];
  // bus acknowledge only for bus errors
  wire bus_clr      = bus_ack_i & bus_err_q;

  logic [3:0] clr_v;
  assign clr_v = {4{cold_start_i}}
               | {1'b0, run_rise | sw_clr_light | bus_clr, 2'h0}
               | {sw_clr_warn, 3'h0};

  wire [3:0] cls_d = set_v | (cls_q & ~clr_v);
  wire       sum_d = |cls_d;

  wire light_bus_new = new_onehot[ecf_pkg::ECF_LIGHT] & err_valid_i & err_i.bus;
  wire bus_err_d     = light_bus_new | (bus_err_q & ~clr_v[ecf_pkg::ECF_LIGHT]);

  logic [CNT_W-1:0] press_q;
  wire press_done = btn_lvl && (press_q == CNT_W'(LONG_PRESS - 1));
  wire [CNT_W-1:0] press_d = !btn_lvl ? '0 :
                             (press_q == CNT_W'(LONG_PRESS)) ? press_q : press_q + 1'b1;

  wire remote_clr = press_done | bus_clr;
  wire remote_d   = (err_valid_i & err_i.bus) | (remote_q & ~remote_clr);

  // class flags and summary
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cls_q     <= ecf_pkg::RST_CLASS;
      sum_q     <= 1'b0;
      bus_err_q <= 1'b0;
    end else begin
      cls_q     <= cls_d;
      sum_q     <= sum_d;
      bus_err_q <= bus_err_d;
    end
  end

  // remote store and button counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      remote_q <= 1'b0;
      press_q  <= '0;
    end else begin
      remote_q <= remote_d;
      press_q  <= press_d;
    end
  end

  // -------------------------------------------------------------------------
  // detail words
  // -------------------------------------------------------------------------
  logic [15:0] det_q [ecf_pkg::DET_N];

  for (genvar i = 0; i < ecf_pkg::DET_N; i++) begin : g_det
    wire sw_wr = we_i & det_hit & (det_idx == 3'(i));
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        det_q[i] <= ecf_pkg::RST_WORD;
      end else if (err_valid_i) begin
        det_q[i] <= err_i.detail[i];
      end else if (sw_wr) begin
        det_q[i] <= wdata_i;
      end
    end
  end

  // -------------------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------------------
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  wire  [3:0] rise_v = cls_d & ~cls_q;
  wire  [3:0] w1c_v  = wr_stat ? wdata_i[3:0] : 4'h0;
  wire  [3:0] irq_stat_d = rise_v | (irq_stat_q & ~w1c_v);
  // new mask reaches the irq output at the write edge, no stale cycle
  wire  [3:0] irq_mask_d = wr_mask ? wdata_i[3:0] : irq_mask_q;

  // sticky status, set wins over clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  logic [15:0] flag_word;
  assign flag_word = {1'b0, cls_q[3], cls_q[2], cls_q[1], cls_q[0], sum_q, 10'h000};

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (addr_i == ecf_pkg::OFS_FLAGS) begin
      rd_mux = flag_word;
    end else if (det_hit) begin
      rd_mux = det_q[det_idx];
    end else if (addr_i == ecf_pkg::OFS_IRQ_STAT) begin
      rd_mux = {12'h000, irq_stat_q};
    end else if (addr_i == ecf_pkg::OFS_IRQ_MASK) begin
      rd_mux = {12'h000, irq_mask_q};
    end else if (addr_i == ecf_pkg::OFS_STATUS) begin
      rd_mux = {14'h0000, remote_q, bus_err_q};
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= re_i ? rd_mux : 16'h0000;
    end
  end

  // -------------------------------------------------------------------------
  // indicator and interrupt outputs
  // -------------------------------------------------------------------------
  // indicators follow flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      class_led_o  <= 4'h0;
      sum_led_o    <= 1'b0;
      bus_led_o    <= 1'b0;
      remote_err_o <= 1'b0;
      remote_clr_o <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      class_led_o  <= cls_d;
      sum_led_o    <= sum_d;
      bus_led_o    <= bus_err_d;
      remote_err_o <= remote_d;
      remote_clr_o <= remote_clr;
      irq_o        <= |(irq_stat_d & irq_mask_d);
    end
  end

endmodule

// ==== ecf_src.sv ====
// ecf_src: fault source standing in for the error detection logic
// assumes: fire_i is driven on clk_i edges by the testbench
`timescale 1ns/100ps
module ecf_src (
  input  wire logic            fire_i,      // raise one error now
  input  wire logic [1:0]      cls_i,       // severity class
  input  wire logic            bus_i,       // error concerns the bus
  input  wire logic [15:0]     word_i,      // detail word value
  output logic                 err_valid_o, // error pulse
  output ecf_pkg::ecf_report_t err_o        // error report
);
  // report, detail inverted while idle so stale data never looks valid
  assign err_valid_o  = fire_i;
  assign err_o.cls    = ecf_pkg::ecf_class_t'(cls_i);
  assign err_o.bus    = bus_i;
  assign err_o.detail = fire_i ? {ecf_pkg::DET_N{word_i}} : {ecf_pkg::DET_N{~word_i}};
endmodule

// ==== ecf_latch_assertions.sv ====
// ecf_latch_assertions: port-level checker for the flag latch
// assumes: bound into every ecf_latch, one clock domain
`timescale 1ns/100ps
module ecf_latch_chk (
  input wire logic                 clk_i,        // system clock
  input wire logic                 arst_n_i,     // async reset
  input wire logic [7:0]           addr_i,       // register address
  input wire logic [15:0]          wdata_i,      // write data
  input wire logic                 we_i,         // write strobe
  input wire logic                 err_valid_i,  // new error pulse
  input wire ecf_pkg::ecf_report_t err_i,        // new error report
  input wire logic [3:0]           cause_i,      // persisting causes
  input wire logic                 ram_fail_i,   // user RAM failure
  input wire logic                 cold_start_i, // cold start pulse
  input wire logic                 bus_ack_i,    // bus acknowledge
  input wire logic [3:0]           class_led_o,  // class flags
  input wire logic                 sum_led_o,    // summary flag
  input wire logic                 bus_led_o,    // bus error stored
  input wire logic                 remote_err_o, // remote error stored
  input wire logic                 remote_clr_o  // remote clear pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // a light error arriving or a light cause present this cycle
  wire light_new = (err_valid_i && err_i.cls == ecf_pkg::ECF_LIGHT) || cause_i[2];
  sequence s_bus_ack;
    bus_led_o && bus_ack_i && !light_new;
  endsequence
  sequence s_acked;
    !bus_led_o && !remote_err_o && !class_led_o[2] && remote_clr_o ##1 !remote_clr_o;
  endsequence
  a_sum_follows: assert property (sum_led_o == |class_led_o)
    else $error("summary flag differs from class flags");
  a_new_err_sets: assert property (err_valid_i |=> class_led_o[$past(err_i.cls)])
    else $error("new error did not set its class");
  a_cause_resets: assert property (cause_i != 4'h0 |=> (class_led_o & $past(cause_i)) == $past(cause_i))
    else $error("persisting cause not set again");
  a_ram_serious: assert property (ram_fail_i |=> class_led_o[1])
    else $error("ram failure not in serious class");
  a_cold_clears: assert property (cold_start_i && !err_valid_i && !ram_fail_i && cause_i == 4'h0
    |=> class_led_o == 4'h0 && !sum_led_o)
    else $error("cold start left flags set");
  a_write_clears: assert property (we_i && addr_i == ecf_pkg::OFS_FLAGS && !wdata_i[13] && !light_new
    |=> !class_led_o[2])
    else $error("write of zero left light flag");
  a_fatal_holds: assert property (class_led_o[0] && !cold_start_i |=> class_led_o[0])
    else $error("fatal flag dropped");
  a_bus_ack_clr: assert property (s_bus_ack |=> s_acked)
    else $error("bus acknowledge did not clear");
endmodule
bind ecf_latch ecf_latch_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .we_i(we_i), .err_valid_i(err_valid_i), .err_i(err_i), .cause_i(cause_i), .ram_fail_i(ram_fail_i),
  .cold_start_i(cold_start_i), .bus_ack_i(bus_ack_i), .class_led_o(class_led_o), .sum_led_o(sum_led_o),
  .bus_led_o(bus_led_o), .remote_err_o(remote_err_o), .remote_clr_o(remote_clr_o));

// ==== test_error_class_flag_latch.sv ====
// test_error_class_flag_latch: directed bench for the flag latch
// assumes: ecf_pkg, ecf_src and the checker are compiled first
`timescale 1ns/100ps
module test_error_class_flag_latch;
  logic clk_i = 0, arst_n_i = 0, we_i = 0, re_i = 0, fire = 0, bus = 0, ram_fail_i = 0, err_valid_i;
  logic cold_start_i = 0, run_stop_i = 0, bus_ack_i = 0, test_btn_i = 0, seen;
  logic sum_led_o, bus_led_o, remote_err_o, remote_clr_o, irq_o;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, word = 16'h0000, d;
  logic [1:0] cls = 2'h0;
  logic [3:0] cause_i = 4'h0, class_led_o;
  ecf_pkg::ecf_report_t err_i;
  int num_errors = 0, n_checks = 0;
  always #20 clk_i = ~clk_i;
  ecf_src u_src (.fire_i(fire), .cls_i(cls), .bus_i(bus), .word_i(word), .err_valid_o(err_valid_i), .err_o(err_i));
  ecf_latch #(.LONG_PRESS(20)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .err_valid_i(err_valid_i), .err_i(err_i), .cause_i(cause_i),
    .ram_fail_i(ram_fail_i), .cold_start_i(cold_start_i), .run_stop_i(run_stop_i), .bus_ack_i(bus_ack_i),
    .test_btn_i(test_btn_i), .class_led_o(class_led_o), .sum_led_o(sum_led_o), .bus_led_o(bus_led_o),
    .remote_err_o(remote_err_o), .remote_clr_o(remote_clr_o), .irq_o(irq_o));
  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic hit(input logic [1:0] c, input logic b, input logic [15:0] w);
    @(posedge clk_i);
    fire <= 1'b1;
    cls <= c;
    bus <= b;
    word <= w;
    @(posedge clk_i);
    fire <= 1'b0;
    #1;
  endtask
  task automatic cold();
    @(posedge clk_i);
    cold_start_i <= 1'b1;
    @(posedge clk_i);
    cold_start_i <= 1'b0;
  endtask
  task automatic t_classes();
    for (int c = 0; c < 4; c++) begin
      hit(c[1:0], 1'b0, 16'h00a0 + 16'(c));
      chk({11'h0, sum_led_o, class_led_o}, 16'h0010 | (16'h0001 << c));
      rd(ecf_pkg::OFS_FLAGS);
      chk(d, 16'h0400 | (16'h0800 << c));
      rd(ecf_pkg::OFS_DET_LAST);
      chk(d, 16'h00a0 + 16'(c));
      cold();
      rd(ecf_pkg::OFS_FLAGS);
      chk(d, 16'h0000);
    end
  endtask
  task automatic t_light();
    hit(2'h2, 1'b0, 16'h1234);
    @(posedge clk_i);
    bus_ack_i <= 1'b1;
    @(posedge clk_i);
    bus_ack_i <= 1'b0;
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h2400);
    wr(ecf_pkg::OFS_FLAGS, 16'h0000);
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h0000);
    wr(ecf_pkg::OFS_DET_BASE, 16'h5a5a);
    rd(ecf_pkg::OFS_DET_BASE);
    chk(d, 16'h5a5a);
  endtask
  task automatic t_bus();
    hit(2'h2, 1'b1, 16'h0042);
    chk({14'h0, bus_led_o, remote_err_o}, 16'h0003);
    rd(ecf_pkg::OFS_STATUS);
    chk(d, 16'h0003);
    @(posedge clk_i);
    bus_ack_i <= 1'b1;
    @(posedge clk_i);
    bus_ack_i <= 1'b0;
    #1 chk({12'h0, class_led_o[2], bus_led_o, remote_err_o, remote_clr_o}, 16'h0001);
    rd(ecf_pkg::OFS_STATUS);
    chk(d, 16'h0000);
    rd(ecf_pkg::OFS_DET_BASE);
    chk(d, 16'h0042);
  endtask
  task automatic t_persist();
    @(posedge clk_i);
    cause_i <= 4'h8;
    wr(ecf_pkg::OFS_FLAGS, 16'h0000);
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h4400);
    @(posedge clk_i);
    cause_i <= 4'h0;
    wr(ecf_pkg::OFS_FLAGS, 16'h0000);
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h0000);
  endtask
  task automatic t_run_press();
    hit(2'h2, 1'b1, 16'h0077);
    @(posedge clk_i);
    run_stop_i <= 1'b1;
    for (int i = 0; i < 10 && class_led_o[2] !== 1'b0; i++) @(posedge clk_i);
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h0000);
    @(posedge clk_i);
    run_stop_i <= 1'b0;
    seen = 1'b0;
    test_btn_i <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_i);
      #1 seen = seen | remote_clr_o;
    end
    @(posedge clk_i);
    test_btn_i <= 1'b0;
    chk({14'h0, seen, remote_err_o}, 16'h0002);
  endtask
  task automatic t_irq_ram();
    wr(ecf_pkg::OFS_IRQ_STAT, 16'h000f);
    wr(ecf_pkg::OFS_IRQ_MASK, 16'h0001);
    #1 chk({15'h0, irq_o}, 16'h0000);
    hit(2'h0, 1'b0, 16'h0001);
    chk({15'h0, irq_o}, 16'h0001);
    rd(ecf_pkg::OFS_IRQ_STAT);
    chk(d, 16'h0001);
    wr(ecf_pkg::OFS_IRQ_STAT, 16'h0001);
    #1 chk({15'h0, irq_o}, 16'h0000);
    wr(ecf_pkg::OFS_IRQ_MASK, 16'h0000);
    cold();
    @(posedge clk_i);
    ram_fail_i <= 1'b1;
    @(posedge clk_i);
    ram_fail_i <= 1'b0;
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h1400);
    cold();
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(ecf_pkg::OFS_FLAGS);
    chk(d, 16'h0000);
    wr(8'h3c, 16'hffff);
    rd(8'h3c);
    chk(d, 16'h0000);
    t_classes();
    t_light();
    t_bus();
    t_persist();
    t_run_press();
    t_irq_ram();
    summarize();
  end
endmodule
